// ===== acs_cfg.svh
// Constants of the converter sequencer: offsets, fields, resets and timing.
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// Register offsets on the 3-bit word address.
`define ACS_OFS_CTRL      3'h0
`define ACS_OFS_CLKSRC    3'h1
`define ACS_OFS_RES_LO    3'h2
`define ACS_OFS_RES_HI    3'h3
`define ACS_OFS_IRQ_STAT  3'h4
`define ACS_OFS_IRQ_MASK  3'h5

// Control register fields.
`define ACS_CTRL_START    7
`define ACS_CTRL_BUSY     6
`define ACS_CTRL_PIN_HI   5
`define ACS_CTRL_PIN_LO   3
`define ACS_CTRL_CH_HI    2
`define ACS_CTRL_CH_LO    0

// Interrupt status bits.
`define ACS_IRQ_DONE      0
`define ACS_IRQ_LATE      1

// Reset values.
`define ACS_RST_CTRL      8'h00
`define ACS_RST_CLKSRC    2'h0
`define ACS_RST_MASK      2'h0

// Timing: clocks per instruction cycle and the reinit window.
`define ACS_INSTR_CLKS       4
`define ACS_REINIT_MAX_INSTR 10
`define ACS_REINIT_CLKS      (`ACS_INSTR_CLKS * `ACS_REINIT_MAX_INSTR)

// Conversion clock half periods in system clocks, one per divider code.
`define ACS_HALF_DIV4     3'h2
`define ACS_HALF_DIV6     3'h3
`define ACS_HALF_DIV8     3'h4
`define ACS_HALF_DIV12    3'h6

`endif

// ===== acs_clkdiv.sv
// Conversion clock divider: system clock divided by 4, 6, 8 or 12.
`timescale 1ns/10ps
`include "acs_cfg.svh"
module acs_clkdiv
    import acs_pkg::*;
(
    input  wire logic       clk,     // System clock.
    input  wire logic       nrst,    // Asynchronous reset, active low.
    input  wire logic [1:0] sel,     // Divider select code.
    output logic            clk_out  // Divided conversion clock.
);

    logic [2:0] cnt_r;

    // Half period in system clocks for each select code.
    function automatic logic [2:0] acs_half(input logic [1:0] s);
        case (s)
            2'b00:   acs_half = `ACS_HALF_DIV4;
            2'b01:   acs_half = `ACS_HALF_DIV6;
            2'b10:   acs_half = `ACS_HALF_DIV8;
            default: acs_half = `ACS_HALF_DIV12;
        endcase
    endfunction : acs_half

    // Toggle at each half period; a select change applies to the phase in
    // progress, which never ends shorter than the new half period.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r   <= 3'h0;
            clk_out <= 1'b0;
        end else if (cnt_r >= acs_half(sel) - 3'h1) begin
            cnt_r   <= 3'h0;
            clk_out <= ~clk_out;
        end else begin
            cnt_r <= cnt_r + 3'h1;
        end
    end

    a_div_half: assert property (@(posedge clk) disable iff (!nrst)
        ($changed(clk_out) && $stable(sel)) |=>
            $stable(clk_out)[*1] ##0 (sel != 2'b11 || $stable(clk_out)))
        else $error("Divided clock toggled too early.");

endmodule : acs_clkdiv

// ===== acs_core_model.sv
// Behavioural model of the analog converter core beside the sequencer.
`timescale 1ns/10ps
module acs_core_model
    import acs_pkg::*;
(
    input  wire logic          clk,    // System clock.
    input  wire logic          nrst,   // Reset, active low.
    input  acs_core_ctl_t      ctl,    // Control from the sequencer.
    input  wire logic [15:0]   dly,    // Conversion length in clocks.
    input  wire logic [11:0]   res_in, // Value the next conversion yields.
    output logic               done,   // Conversion finished, level.
    output logic      [11:0]   result  // Result word.
);
    logic [15:0] cnt_r;
    logic [11:0] val_r;

    // Count down after a launch pulse; a held reset aborts the conversion.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 16'h0000;
            done  <= 1'b0;
            val_r <= 12'h000;
        end else if (ctl.rst) begin
            cnt_r <= 16'h0000;
            done  <= 1'b0;
        end else if (ctl.start) begin
            cnt_r <= dly;
            done  <= 1'b0;
            val_r <= res_in;
        end else if (cnt_r == 16'h0001) begin
            cnt_r <= 16'h0000;
            done  <= 1'b1;
        end else if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
        end
    end

    // Outside done the word is inverted, so a stale sample cannot pass.
    assign result = done ? val_r : ~val_r;
endmodule : acs_core_model

// ===== acs_pkg.sv
// Types shared by the converter sequencer modules.
package acs_pkg;

    // Control bundle driven toward the analog converter core.
    typedef struct packed {
        logic       pwr;
        logic       rst;
        logic       start;
        logic [2:0] chan;
    } acs_core_ctl_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_HOLD = 2'b01,
        ACS_CONV = 2'b10
    } acs_state_t;

endpackage : acs_pkg

// ===== acs_top.sv
// Converter sequencer: registers, start handling, busy flag and results.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "acs_cfg.svh"
module acs_top
    import acs_pkg::*;
(
    input  wire logic          clk,           // System clock, 100 MHz.
    input  wire logic          nrst,          // Async reset, active low.
    input  wire logic [2:0]    bus_addr,      // Register word address.
    input  wire logic [7:0]    bus_wdata,     // Write data.
    input  wire logic          bus_wr,        // Write strobe.
    input  wire logic          bus_rd,        // Read strobe.
    output logic      [7:0]    bus_rdata,     // Read data, next cycle.
    output logic               core_clk,      // Conversion clock to core.
    output acs_core_ctl_t      core_ctl,      // Control to core.
    input  wire logic          core_done,     // Core finished, async level.
    input  wire logic [11:0]   core_result,   // Core result word.
    output logic      [7:0]    pin_analog_en, // Port pins in analog mode.
    output logic               irq            // Interrupt, active high.
);

    localparam logic [5:0] REINIT_CLKS = 6'(`ACS_REINIT_CLKS);

    acs_state_t  state_r;
    logic [2:0]  pin_cfg_r;
    logic [2:0]  chan_sel_r;
    logic        start_r;
    logic        busy_r;
    logic [1:0]  div_sel_r;
    logic [7:0]  res_hi_r;
    logic [3:0]  res_lo_r;
    logic [1:0]  irq_stat_r;
    logic [1:0]  irq_mask_r;
    logic [2:0]  done_sync_r;
    logic        done_lvl_r;
    logic        reinit_pend_r;
    logic [5:0]  reinit_cnt_r;
    logic        wr_ctrl;
    logic        start_rise;
    logic        start_fall;
    logic        done_rise;
    logic        late_evt;
    logic [1:0]  irq_set;

    // Pin configuration decode: which port pins become analog inputs.
    function automatic logic [7:0] acs_pins(input logic [2:0] cfg);
        case (cfg)
            3'b000:  acs_pins = 8'h00;
            3'b001:  acs_pins = 8'h01;
            3'b010:  acs_pins = 8'h03;
            3'b011:  acs_pins = 8'h07;
            3'b100:  acs_pins = 8'h0E;
            3'b101:  acs_pins = 8'h3F;
            3'b110:  acs_pins = 8'h3F;
            default: acs_pins = 8'hFF;
        endcase
    endfunction : acs_pins

    // Write decode for the start bit edges.
    assign wr_ctrl    = bus_wr && (bus_addr == `ACS_OFS_CTRL);
    assign start_rise = wr_ctrl && bus_wdata[`ACS_CTRL_START] && !start_r;
    assign start_fall = wr_ctrl && !bus_wdata[`ACS_CTRL_START] && start_r;

    // The done level crosses in through three flops; it counts only
    // once the second and third stages agree, which filters glitches.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            done_sync_r <= 3'h0;
            done_lvl_r  <= 1'b0;
        end else begin
            done_sync_r <= {done_sync_r[1:0], core_done};
            if (done_sync_r[1] == done_sync_r[2]) begin
                done_lvl_r <= done_sync_r[2];
            end
        end
    end
    assign done_rise = (done_sync_r[1] == done_sync_r[2]) &&
                       done_sync_r[2] && !done_lvl_r;

    // Software-written configuration; pin and channel share one write.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_cfg_r  <= 3'(`ACS_RST_CTRL >> `ACS_CTRL_PIN_LO);
            chan_sel_r <= 3'h0;
            start_r    <= 1'b0;
            div_sel_r  <= `ACS_RST_CLKSRC;
            irq_mask_r <= `ACS_RST_MASK;
        end else if (bus_wr) begin
            if (bus_addr == `ACS_OFS_CTRL) begin
                pin_cfg_r  <= bus_wdata[`ACS_CTRL_PIN_HI:`ACS_CTRL_PIN_LO];
                chan_sel_r <= bus_wdata[`ACS_CTRL_CH_HI:`ACS_CTRL_CH_LO];
                start_r    <= bus_wdata[`ACS_CTRL_START];
            end
            if (bus_addr == `ACS_OFS_CLKSRC) begin
                div_sel_r <= bus_wdata[1:0];
            end
            if (bus_addr == `ACS_OFS_IRQ_MASK) begin
                irq_mask_r <= bus_wdata[1:0];
            end
        end
    end

    // Sequencer: start high holds the core in reset with busy high; the
    // falling edge launches a conversion on the channel stored before that write.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r  <= ACS_IDLE;
            busy_r   <= 1'b0;
            core_ctl <= '0;
        end else begin
            core_ctl.start <= 1'b0;
            core_ctl.pwr   <= (pin_cfg_r != 3'h0);
            case (state_r)
                ACS_IDLE, ACS_CONV: begin
                    if (start_rise) begin
                        state_r      <= ACS_HOLD;
                        busy_r       <= 1'b1;
                        core_ctl.rst <= 1'b1;
                    end else if (state_r == ACS_CONV && done_rise) begin
                        state_r <= ACS_IDLE;
                        busy_r  <= 1'b0;
                    end
                end
                ACS_HOLD: begin
                    if (start_fall) begin
                        state_r        <= ACS_CONV;
                        core_ctl.rst   <= 1'b0;
                        core_ctl.start <= 1'b1;
                        core_ctl.chan  <= chan_sel_r;
                    end
                end
                default: begin
                    state_r <= ACS_IDLE;
                end
            endcase
        end
    end

    // Results load only on completion; they stand until the next one.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            res_hi_r <= 8'h00;
            res_lo_r <= 4'h0;
        end else if (state_r == ACS_CONV && done_rise && !start_rise) begin
            res_hi_r <= core_result[11:4];
            res_lo_r <= core_result[3:0];
        end
    end

    // Reinit watch: a channel change opens a window counted in system
    // clocks; missing it only flags software, the hardware goes on.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reinit_pend_r <= 1'b0;
            reinit_cnt_r  <= 6'h00;
        end else if (start_rise) begin
            reinit_pend_r <= 1'b0;
            reinit_cnt_r  <= 6'h00;
        end else if (wr_ctrl && bus_wdata[2:0] != chan_sel_r) begin
            reinit_pend_r <= 1'b1;
            reinit_cnt_r  <= 6'h00;
        end else if (reinit_pend_r) begin
            reinit_cnt_r <= reinit_cnt_r + 6'h01;
            if (late_evt) begin
                reinit_pend_r <= 1'b0;
            end
        end
    end
    assign late_evt = reinit_pend_r && (reinit_cnt_r == REINIT_CLKS);

    // Sticky status: a read clears it, but a same-cycle event wins.
    assign irq_set = {late_evt,
                      state_r == ACS_CONV && done_rise && !start_rise};
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat_r <= 2'h0;
        end else if (bus_rd && bus_addr == `ACS_OFS_IRQ_STAT) begin
            irq_stat_r <= irq_set;
        end else begin
            irq_stat_r <= irq_stat_r | irq_set;
        end
    end

    // Registered outputs: interrupt level and analog pin enables.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq           <= 1'b0;
            pin_analog_en <= 8'h00;
        end else begin
            irq           <= |(irq_stat_r & irq_mask_r);
            pin_analog_en <= acs_pins(pin_cfg_r);
        end
    end

    // Read data stands one cycle after the strobe; unmapped reads zero.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_rdata <= 8'h00;
        end else if (bus_rd) begin
            case (bus_addr)
                `ACS_OFS_CTRL:     bus_rdata <= {start_r, busy_r, pin_cfg_r,
                                                 chan_sel_r};
                `ACS_OFS_CLKSRC:   bus_rdata <= {6'h00, div_sel_r};
                `ACS_OFS_RES_LO:   bus_rdata <= {res_lo_r, 4'h0};
                `ACS_OFS_RES_HI:   bus_rdata <= res_hi_r;
                `ACS_OFS_IRQ_STAT: bus_rdata <= {6'h00, irq_stat_r};
                `ACS_OFS_IRQ_MASK: bus_rdata <= {6'h00, irq_mask_r};
                default:           bus_rdata <= 8'h00;
            endcase
        end else begin
            bus_rdata <= 8'h00;
        end
    end

    // Conversion clock from the selectable divider.
    acs_clkdiv u_div (
        .clk     (clk),
        .nrst    (nrst),
        .sel     (div_sel_r),
        .clk_out (core_clk)
    );

    sequence s_start_pulse;
        start_rise ##[1:100] start_fall;
    endsequence

    a_rise_sets_busy: assert property (
        @(posedge clk) disable iff (!nrst)
        start_rise |=> busy_r && core_ctl.rst)
        else $error("Start rise did not force busy and reset.");
    a_hold_reset: assert property (
        @(posedge clk) disable iff (!nrst)
        (state_r == ACS_HOLD) |-> (busy_r && core_ctl.rst))
        else $error("Held start did not keep core in reset.");
    a_pulse_starts: assert property (
        @(posedge clk) disable iff (!nrst)
        s_start_pulse |=> core_ctl.start ##1 !core_ctl.start)
        else $error("Start pulse did not launch one conversion.");
    // Busy and the done status bit change at the same edge, so a status
    // read right after completion must still find the bit set.
    a_done_clears: assert property (
        @(posedge clk) disable iff (!nrst)
        (state_r == ACS_CONV && done_rise && !start_rise) |=>
            !busy_r && irq_stat_r[`ACS_IRQ_DONE])
        else $error("Completion did not clear busy or set status.");
    a_result_hold: assert property (
        @(posedge clk) disable iff (!nrst)
        !(state_r == ACS_CONV && done_rise) |=>
            $stable(res_hi_r) && $stable(res_lo_r))
        else $error("Result changed without completion.");
    a_chan_locked: assert property (
        @(posedge clk) disable iff (!nrst)
        (state_r == ACS_CONV && !done_rise && !start_rise) |=>
            $stable(core_ctl.chan))
        else $error("Channel changed during conversion.");
    a_res_read: assert property (
        @(posedge clk) disable iff (!nrst)
        (bus_rd && bus_addr == `ACS_OFS_RES_HI) |=>
            bus_rdata == $past(res_hi_r))
        else $error("High result read returned wrong data.");
    a_irq_level: assert property (
        @(posedge clk) disable iff (!nrst)
        ##1 irq == $past(|(irq_stat_r & irq_mask_r)))
        else $error("Interrupt output does not follow status.");
    a_late_window: assert property (
        @(posedge clk) disable iff (!nrst)
        late_evt |-> $past(reinit_pend_r, 40))
        else $error("Late flag raised before window expired.");

endmodule : acs_top

// ===== tb_top.sv
// Self-checking testbench of the converter sequencer.
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top
    import acs_pkg::*;
;
    logic          clk = 1'b0;
    logic          nrst = 1'b0;
    logic [2:0]    bus_addr;
    logic [7:0]    bus_wdata, bus_rdata, pin_analog_en, exp_v;
    logic          bus_wr, bus_rd, rd_d = 1'b0, core_clk, core_done, irq;
    acs_core_ctl_t core_ctl;
    logic [11:0]   core_result, res_in;
    logic [15:0]   dly;
    logic [7:0]    rq[$];
    int            err_count = 0, num_checks = 0, cyc = 0, seed, r;
    time           t0;
    logic [7:0]    pin_tab[8] = '{8'h00, 8'h01, 8'h03, 8'h07,
                                  8'h0E, 8'h3F, 8'h3F, 8'hFF};
    int            div_tab[4] = '{4, 6, 8, 12};

    acs_top uut (.clk(clk), .nrst(nrst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .core_clk(core_clk), .core_ctl(core_ctl),
        .core_done(core_done), .core_result(core_result),
        .pin_analog_en(pin_analog_en), .irq(irq));
    acs_core_model model (.clk(clk), .nrst(nrst), .ctl(core_ctl),
        .dly(dly), .res_in(res_in), .done(core_done),
        .result(core_result));

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    // Read data stand only in the cycle after the strobe; sample mid-cycle.
    always @(posedge clk) rd_d <= bus_rd;
    always @(negedge clk) begin
        if (rd_d) begin
            exp_v = rq.pop_front();
            `CHK(bus_rdata, exp_v)
        end
    end

    // A hang is cut short well beyond the length of all tests.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end

    // One write cycle; the gap edge keeps strobes from being set twice.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge clk);
        bus_wr    <= 1'b0;
    endtask : wr

    // One read cycle; the expected byte is noted for the watcher.
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        rq.push_back(e);
        @(posedge clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge clk);
        bus_rd   <= 1'b0;
    endtask : rd

    // Bounded wait for the core to finish, then room for sync and flags.
    task automatic wait_done();
        for (int i = 0; i < 500 && core_done !== 1'b1; i++) @(posedge clk);
        `CHK(core_done, 1'b1)
        repeat (8) @(posedge clk);
    endtask : wait_done

    // Print the counts and the verdict, then stop.
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    // Main sequence.
    initial begin
        seed = 32'hbc73_436d;
        {bus_addr, bus_wdata, bus_wr, bus_rd} = '0;
        dly = 16'h0050;
        res_in = 12'h000;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        rd(3'h0, 8'h00);
        rd(3'h1, 8'h00);
        rd(3'h5, 8'h00);
        rd(3'h6, 8'h00);
        $display("test reset values done");
        for (int p = 0; p < 8; p++) begin
            wr(3'h0, {2'b00, p[2:0], 3'b000});
            repeat (2) @(posedge clk);
            `CHK(pin_analog_en, pin_tab[p])
            `CHK(core_ctl.pwr, (p != 0))
        end
        $display("test pin config done");
        for (int s = 0; s < 4; s++) begin
            wr(3'h1, s[7:0]);
            repeat (3) @(posedge core_clk);
            t0 = $time;
            @(posedge core_clk);
            `CHK(int'(($time - t0) / 10), div_tab[s])
        end
        rd(3'h1, 8'h03);
        $display("test divider done");
        // Slow conversion with a channel change in flight and irq unmasked.
        wr(3'h5, 8'h01);
        r = $random(seed);
        res_in <= r[11:0];
        wr(3'h0, 8'h89);
        @(posedge clk);
        `CHK(core_ctl.rst, 1'b1)
        rd(3'h0, 8'hC9);
        wr(3'h0, 8'h09);
        rd(3'h0, 8'h49);
        `CHK(core_ctl.chan, 3'd1)
        wr(3'h0, 8'h0D);
        rd(3'h0, 8'h4D);
        `CHK(core_ctl.chan, 3'd1)
        wait_done();
        rd(3'h0, 8'h0D);
        rd(3'h3, r[11:4]);
        rd(3'h2, {r[3:0], 4'h0});
        `CHK(irq, 1'b1)
        rd(3'h4, 8'h03);
        rd(3'h4, 8'h00);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b0)
        $display("test slow conversion done");
        // Prompt conversion after a proper reinit, interrupt masked.
        wr(3'h5, 8'h00);
        dly <= 16'h0003;
        r = $random(seed);
        res_in <= r[11:0];
        wr(3'h0, 8'h0A);
        wr(3'h0, 8'h8A);
        wr(3'h0, 8'h0A);
        rd(3'h0, 8'h4A);
        wait_done();
        rd(3'h3, r[11:4]);
        rd(3'h2, {r[3:0], 4'h0});
        `CHK(irq, 1'b0)
        rd(3'h4, 8'h01);
        $display("test prompt conversion done");
        // Start left high keeps the converter in reset and busy high.
        wr(3'h0, 8'h89);
        repeat (20) @(posedge clk);
        rd(3'h0, 8'hC9);
        `CHK(core_ctl.rst, 1'b1)
        `CHK(core_done, 1'b0)
        wr(3'h0, 8'h09);
        wait_done();
        rd(3'h0, 8'h09);
        $display("test start held done");
        conclude();
    end
endmodule : tb_top
